/* File: acc_clk_div.sv */
// acc_clk_div: converter clock prescaler, gives one enable pulse per converter clock
// assumes the select code is stable enough; a change keeps the count, which wraps at once if already past the new end
`timescale 1ns/1ps
module acc_clk_div (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  // tick out
  output logic            tick
);
  import acc_pkg::*;

  logic [6:0] cnt_q;
  logic [6:0] last;

  // R16: divider decode, 000 and 001 give two
  always_comb begin
    if (div_sel <= 3'h1) begin
      last = 7'h01;
    end else begin
      last = 7'(( 8'h01 << div_sel) - 8'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
    end else if (ce) begin
      if (!run || cnt_q >= last) begin
        cnt_q <= 7'h00;
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  assign tick = ce && run && (cnt_q >= last);
endmodule // acc_clk_div

/* File: acc_core_model.sv */
// acc_core_model: analog core stand-in, one code per sample strobe
// assumes the strobe marks the sampling cycle; outside it the lines churn
`timescale 1ns/1ps
module acc_core_model (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // converter side
  input  wire logic                     conv_on,
  input  wire logic                     sample_strobe,
  input  wire acc_pkg::acc_analog_cfg_t cfg,
  output logic [9:0]                    sample_data,
  output logic [9:0]                    last_value
);
  import acc_pkg::*;
  logic [4:0] n_q;
  logic [9:0] churn_q;
  // channel in the low bits shows which input was really sampled
  assign sample_data = (sample_strobe && conv_on) ? {n_q, cfg.channel} : churn_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_q        <= 5'h00;
      churn_q    <= 10'h000;
      last_value <= 10'h000;
    end else begin
      churn_q <= {churn_q[8:0], ~churn_q[9]};
      if (sample_strobe && conv_on) begin
        n_q        <= n_q + 5'h01;
        last_value <= sample_data;
      end
    end
  end
endmodule // acc_core_model

/* File: acc_ctrl.sv */
// acc_ctrl: converter control, register file, triggering and result handling
// assumes the analog core delivers a 10-bit sample when asked; triggers arrive from pins
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// R1: amplified channel auto trigger waits for next amplifier clock after trigger
// R2: software rearms go bit after each amplified auto conversion
// R3: reference select change applies only after conversion completes
// R4: reference decoded from pin connect, current source and field; here decoded from the input select field only
// R5: internal reference powered whenever converter enabled and reference internal
// R6: alignment bit reshapes the result view immediately
// R7: channel select change held off until conversion completes
// R8: channel codes map external inputs, sensors, amplifiers; others reserved
// R9: enable turns converter on; clear applies at end of conversion
// R10: go bit launches single conversion, or first free-running one
// R11: go reads one during conversion; writing zero ignored
// R12: auto trigger uses selected source; clear returns single mode
// R13: done flag set when result registers updated
// R14: interrupt requested with flag, enable and global enable
// R15: flag cleared by vector taken or writing one
// R16: divider select sets converter clock; codes 000, 001 divide two
// R17: auto start on rising edge of source flag; 0000 free runs
// R18: low byte read locks result until high byte read
// R19: writing zero to flag position keeps the flag
module acc_ctrl #(
  parameter int CONV_CYCLES = acc_pkg::ACC_CONV_CYCLES,
  parameter int AMP_DIV     = acc_pkg::ACC_AMP_DIV
) (
  // clock and reset
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  input  wire logic                    CLK_EN,
  // register port
  input  wire acc_pkg::acc_bus_req_t   BUS_REQ,
  output logic [7:0]                   BUS_RDATA,
  // processor side
  input  wire logic                    GLOBAL_IRQ_EN,
  input  wire logic                    IRQ_ACK,
  output logic                         IRQ_REQ,
  // trigger sources, asynchronous
  input  wire logic [13:0]             TRIG_SRC,
  // analog core
  input  wire logic [9:0]              SAMPLE_DATA,
  output acc_pkg::acc_analog_cfg_t     ANALOG_CFG,
  output logic                         CONV_ON,
  output logic                         SAMPLE_STROBE,
  output logic                         HIGH_SPEED,
  output logic                         CURRENT_SOURCE_ON,
  output logic                         REF_PIN_CONNECT
);
  import acc_pkg::*;

  typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT_AMP, ACC_CONV} acc_state_t;

  logic [7:0]      csr_a_q, csr_b_q, in_sel_q;
  logic            go_q, done_q, on_q;
  logic [9:0]      result_q;
  logic            lock_q;
  logic [13:0]     trg_s1_q, trg_s2_q, trg_d_q;
  logic            trg_pend_q;
  logic            first_q;
  logic [4:0]      cyc_q;
  logic [2:0]      amp_q;
  acc_state_t      st_q;
  acc_analog_cfg_t cfg_q;
  acc_ref_t        ref_now;
  logic            div_tick, amp_tick, trg_edge, finish, wr_a, start_req, amp_chan;

  // decode of reference source from the input select field
  function automatic acc_ref_t ref_decode(input logic [1:0] f);
    case (f)
      2'b00:   ref_decode = ACC_REF_PIN;
      2'b01:   ref_decode = ACC_REF_SUPPLY;
      2'b11:   ref_decode = ACC_REF_INTERNAL;
      default: ref_decode = ACC_REF_RESERVED;
    endcase
  endfunction

  function automatic logic is_amp(input logic [4:0] ch);
    is_amp = (ch >= ACC_CH_GAIN_CHANNEL_0) && (ch <= ACC_CH_GAIN_CHANNEL_2);
  endfunction

  assign wr_a = BUS_REQ.wr && BUS_REQ.addr == ACC_OFS_CSR_A;

  acc_clk_div u_div (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ce      (CLK_EN),
    .run     (on_q),
    .div_sel (csr_a_q[ACC_A_DIV_H:0]),
    .tick    (div_tick)
  );

  // amplifier clock: converter clock divided by eight
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      amp_q <= 3'h0;
    end else if (CLK_EN && div_tick) begin
      amp_q <= amp_q + 3'h1;
    end
  end
  assign amp_tick = div_tick && (amp_q == 3'(AMP_DIV - 1));

  // trigger sync, two flops before any edge detect
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trg_s1_q <= '0;
      trg_s2_q <= '0;
      trg_d_q  <= '0;
    end else if (CLK_EN) begin
      trg_s1_q <= TRIG_SRC;
      trg_s2_q <= trg_s1_q;
      trg_d_q  <= trg_s2_q;
    end
  end

  // R17: rising edge start
  always_comb begin
    trg_edge = 1'b0;
    if (csr_b_q[ACC_B_TRG_H:0] != ACC_TRG_FREE && int'(csr_b_q[ACC_B_TRG_H:0]) < ACC_TRG_NUM) begin
      trg_edge = trg_s2_q[csr_b_q[ACC_B_TRG_H:0]] && !trg_d_q[csr_b_q[ACC_B_TRG_H:0]];
    end
  end

  // plain control registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      csr_a_q  <= ACC_RST_CSR_A;
      csr_b_q  <= ACC_RST_CSR_B;
      in_sel_q <= ACC_RST_IN_SEL;
    end else if (CLK_EN && BUS_REQ.wr) begin
      case (BUS_REQ.addr)
        ACC_OFS_CSR_A:  csr_a_q  <= BUS_REQ.wdata;
        ACC_OFS_CSR_B:  csr_b_q  <= BUS_REQ.wdata;
        ACC_OFS_IN_SEL: in_sel_q <= BUS_REQ.wdata;
        default:        csr_a_q  <= csr_a_q;
      endcase
    end
  end

  assign finish   = (st_q == ACC_CONV) && div_tick && (cyc_q == 5'(CONV_CYCLES - 1));
  assign amp_chan = is_amp(in_sel_q[ACC_M_CH_H:0]);

  // reference in force: live while idle, frozen for the running conversion
  assign ref_now = (st_q == ACC_IDLE) ? ref_decode(in_sel_q[ACC_M_REF_H:ACC_M_REF_L])
                                      : cfg_q.ref_src;

  // R10: software start; R12: auto start sources
  always_comb begin
    start_req = 1'b0;
    if (wr_a && BUS_REQ.wdata[ACC_A_GO] && BUS_REQ.wdata[ACC_A_ON]) begin
      start_req = 1'b1;
    end else if (csr_a_q[ACC_A_AUTO] && on_q && !first_q) begin
      // R2: amplified auto mode has no free running
      if (csr_b_q[ACC_B_TRG_H:0] == ACC_TRG_FREE && !amp_chan) begin
        start_req = 1'b1;
      end
    end
  end

  // conversion sequencer
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q       <= ACC_IDLE;
      cyc_q      <= 5'h00;
      go_q       <= 1'b0;
      first_q    <= 1'b1;
      trg_pend_q <= 1'b0;
      // code 00000 is a real input, so the reset view is valid
      cfg_q      <= '{ref_src: ACC_REF_PIN, int_ref_on: 1'b0, channel: 5'h00, chan_valid: 1'b1};
    end else if (CLK_EN) begin
      // a powered-off converter never ticks, so a kept trigger would hang it
      if (trg_edge && csr_a_q[ACC_A_AUTO] && on_q) begin
        trg_pend_q <= 1'b1;
      end
      // R3: R7: mux and reference follow the register only between conversions
      if (st_q == ACC_IDLE) begin
        cfg_q.ref_src    <= ref_now;
        cfg_q.channel    <= in_sel_q[ACC_M_CH_H:0];
        // R8: codes above ground reserved
        cfg_q.chan_valid <= in_sel_q[ACC_M_CH_H:0] <= ACC_CH_GND;
      end
      case (st_q)
        ACC_IDLE: begin
          if (start_req || (trg_edge && csr_a_q[ACC_A_AUTO] && on_q) || (trg_pend_q && on_q)) begin
            // R11: go reads one while busy
            go_q       <= 1'b1;
            first_q    <= 1'b0;
            trg_pend_q <= 1'b0;
            cyc_q      <= 5'h00;
            // R1: amplified auto start waits on amplifier clock
            if (csr_a_q[ACC_A_AUTO] && amp_chan && !start_req) begin
              st_q <= ACC_WAIT_AMP;
            end else begin
              st_q <= ACC_CONV;
            end
          end
        end
        ACC_WAIT_AMP: begin
          if (amp_tick) begin
            st_q <= ACC_CONV;
          end
        end
        ACC_CONV: begin
          if (div_tick) begin
            cyc_q <= cyc_q + 5'h01;
          end
          if (finish) begin
            go_q <= 1'b0;
            st_q <= ACC_IDLE;
          end
        end
        default: st_q <= ACC_IDLE;
      endcase
      // R5: internal reference powered with converter
      cfg_q.int_ref_on <= on_q && ref_now == ACC_REF_INTERNAL;
      if (!csr_a_q[ACC_A_ON] && st_q == ACC_IDLE) begin
        first_q <= 1'b1;
      end
    end
  end

  // R9: off takes effect when idle or as the conversion finishes
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      on_q <= 1'b0;
    end else if (CLK_EN) begin
      if (csr_a_q[ACC_A_ON]) begin
        on_q <= 1'b1;
      end else if (st_q == ACC_IDLE || finish) begin
        on_q <= 1'b0;
      end
    end
  end

  // R13: R18: result update unless low byte locked
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_q <= 10'h000;
      lock_q   <= 1'b0;
    end else if (CLK_EN) begin
      if (finish && !lock_q) begin
        result_q <= SAMPLE_DATA;
      end
      if (BUS_REQ.rd && BUS_REQ.addr == ACC_OFS_RES_HI) begin
        lock_q <= 1'b0;
      end else if (BUS_REQ.rd && BUS_REQ.addr == ACC_OFS_RES_LO) begin
        lock_q <= 1'b1;
      end
    end
  end

  // done flag: set wins over both clears
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_q <= 1'b0;
    end else if (CLK_EN) begin
      if (finish && !lock_q) begin
        // R13: flag on result update
        done_q <= 1'b1;
      end else if (IRQ_ACK || (wr_a && BUS_REQ.wdata[ACC_A_DONE])) begin
        // R15: R19: only a one clears
        done_q <= 1'b0;
      end
    end
  end

  // read data: one cycle after strobe, R6 alignment applied live
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_RDATA <= 8'h00;
    end else if (CLK_EN) begin
      BUS_RDATA <= 8'h00;
      if (BUS_REQ.rd) begin
        case (BUS_REQ.addr)
          ACC_OFS_RES_LO: BUS_RDATA <= in_sel_q[ACC_M_LEFT] ? {result_q[1:0], 6'h00}
                                                             : result_q[7:0];
          ACC_OFS_RES_HI: BUS_RDATA <= in_sel_q[ACC_M_LEFT] ? result_q[9:2]
                                                             : {6'h00, result_q[9:8]};
          ACC_OFS_CSR_A:  BUS_RDATA <= {csr_a_q[ACC_A_ON], go_q, csr_a_q[ACC_A_AUTO], done_q,
                                        csr_a_q[ACC_A_IRQEN:0]};
          ACC_OFS_CSR_B:  BUS_RDATA <= {csr_b_q[7:5], 1'b0, csr_b_q[ACC_B_TRG_H:0]};
          ACC_OFS_IN_SEL: BUS_RDATA <= in_sel_q;
          default:        BUS_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // R14: interrupt request
  assign IRQ_REQ           = done_q && csr_a_q[ACC_A_IRQEN] && GLOBAL_IRQ_EN;
  // R4: loose reference bits drive the analog switches
  assign ANALOG_CFG        = cfg_q;
  assign CURRENT_SOURCE_ON = csr_b_q[ACC_B_CURRENT_SOURCE_INPUT];
  assign REF_PIN_CONNECT   = csr_b_q[ACC_B_PIN];
  assign HIGH_SPEED        = csr_b_q[ACC_B_HSM];
  assign CONV_ON           = on_q;
  assign SAMPLE_STROBE     = finish;
endmodule // acc_ctrl

/* File: acc_monitor.sv */
// acc_monitor: port checks for the converter control block
// assumes it is bound to acc_ctrl, one clock domain
`timescale 1ns/1ps
module acc_monitor (
  // clock and reset
  input wire logic                     CORE_CLK,
  input wire logic                     RST_N,
  input wire logic                     CLK_EN,
  // processor and analog side
  input wire logic                     GLOBAL_IRQ_EN,
  input wire logic                     IRQ_ACK,
  input wire logic                     IRQ_REQ,
  input wire logic                     CONV_ON,
  input wire logic                     SAMPLE_STROBE,
  input wire acc_pkg::acc_analog_cfg_t ANALOG_CFG
);
  import acc_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence conv_end_s;
    SAMPLE_STROBE && CLK_EN;
  endsequence
  // a completion that updates the result in the same cycle wins over the vector taken
  sequence ack_only_s;
    IRQ_ACK && CLK_EN && !SAMPLE_STROBE;
  endsequence
  irq_gate_a: assert property (
    IRQ_REQ |-> GLOBAL_IRQ_EN) else $error("request without global enable");
  ack_clear_a: assert property (
    ack_only_s |=> !IRQ_REQ) else $error("request kept after vector");
  strobe_power_a: assert property (
    SAMPLE_STROBE |-> CONV_ON) else $error("sample while powered off");
  strobe_pulse_a: assert property (
    conv_end_s |=> !SAMPLE_STROBE) else $error("sample strobe too long");
  chan_hold_a: assert property (
    SAMPLE_STROBE |-> $stable(ANALOG_CFG.channel)) else $error("channel moved at sample");
  ref_hold_a: assert property (
    SAMPLE_STROBE |-> $stable(ANALOG_CFG.ref_src)) else $error("reference moved at sample");
  int_ref_a: assert property (
    ANALOG_CFG.int_ref_on |-> ANALOG_CFG.ref_src == ACC_REF_INTERNAL)
    else $error("internal reference on while not chosen");
  chan_code_a: assert property (
    ANALOG_CFG.chan_valid == (ANALOG_CFG.channel <= ACC_CH_GND))
    else $error("channel validity wrong");
endmodule // acc_monitor

/* File: acc_pkg.sv */
// acc_pkg: register map, field positions and shared types for the converter control block
// assumes an 8-bit register port and a single system clock domain
package acc_pkg;

  // register offsets
  localparam logic [7:0] ACC_OFS_RES_LO  = 8'h78;
  localparam logic [7:0] ACC_OFS_RES_HI  = 8'h79;
  localparam logic [7:0] ACC_OFS_CSR_A   = 8'h7A;
  localparam logic [7:0] ACC_OFS_CSR_B   = 8'h7B;
  localparam logic [7:0] ACC_OFS_IN_SEL  = 8'h7C;

  // reset values
  localparam logic [7:0] ACC_RST_CSR_A   = 8'h00;
  localparam logic [7:0] ACC_RST_CSR_B   = 8'h00;
  localparam logic [7:0] ACC_RST_IN_SEL  = 8'h00;

  // control/status A fields
  localparam int ACC_A_ON    = 7;
  localparam int ACC_A_GO    = 6;
  localparam int ACC_A_AUTO  = 5;
  localparam int ACC_A_DONE  = 4;
  localparam int ACC_A_IRQEN = 3;
  localparam int ACC_A_DIV_H = 2;

  // control/status B fields
  localparam int ACC_B_HSM   = 7;
  localparam int ACC_B_CURRENT_SOURCE_INPUT  = 6;
  localparam int ACC_B_PIN   = 5;
  localparam int ACC_B_TRG_H = 3;

  // input select fields
  localparam int ACC_M_REF_H = 7;
  localparam int ACC_M_REF_L = 6;
  localparam int ACC_M_LEFT  = 5;
  localparam int ACC_M_CH_H  = 4;

  // channel codes
  localparam logic [4:0] ACC_CH_EXT_LAST = 5'h0A;
  localparam logic [4:0] ACC_CH_TEMP     = 5'h0B;
  localparam logic [4:0] ACC_CH_GAIN_CHANNEL_0     = 5'h0E;
  localparam logic [4:0] ACC_CH_GAIN_CHANNEL_2     = 5'h10;
  localparam logic [4:0] ACC_CH_GND      = 5'h12;

  localparam logic [3:0] ACC_TRG_FREE    = 4'h0;
  localparam int         ACC_TRG_NUM     = 14;

  // converter core timing and clocks
  localparam int ACC_CONV_CYCLES = 13;
  localparam int ACC_AMP_DIV     = 8;

  typedef enum logic [1:0] {
    ACC_REF_PIN,
    ACC_REF_SUPPLY,
    ACC_REF_INTERNAL,
    ACC_REF_RESERVED
  } acc_ref_t;

  // settings latched into the analog side for one conversion
  typedef struct packed {
    acc_ref_t   ref_src;
    logic       int_ref_on;
    logic [4:0] channel;
    logic       chan_valid;
  } acc_analog_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acc_bus_req_t;

endpackage : acc_pkg

/* File: tb.sv */
// tb: self-checking bench for acc_ctrl beside the analog core model
// assumes acc_pkg, acc_ctrl, acc_core_model and acc_monitor compiled first
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;
  localparam logic [7:0] CA = ACC_OFS_CSR_A;
  localparam logic [7:0] MX = ACC_OFS_IN_SEL;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            glob = 1'b0;
  logic            ack = 1'b0;
  logic [13:0]     trig = '0;
  acc_bus_req_t    bus = '0;
  logic [7:0]      rdata, v, lo;
  logic [9:0]      sdata, last, exp_v;
  logic [4:0]      ch;
  logic            conv_on, strobe, irq;
  acc_analog_cfg_t cfg;
  acc_ref_t        rtab [4] = '{ACC_REF_PIN, ACC_REF_SUPPLY, ACC_REF_RESERVED, ACC_REF_INTERNAL};
  int              n_fail = 0;
  int              samples_checked = 0;
  int              cyc = 0;
  int              seed = 32'hbab9;
  int              c, f;
  int              t_sb = 0;
  int              t0 = 0;

  always #5 clk = ~clk;

  acc_ctrl uut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .BUS_REQ(bus), .BUS_RDATA(rdata),
    .GLOBAL_IRQ_EN(glob), .IRQ_ACK(ack), .IRQ_REQ(irq), .TRIG_SRC(trig), .SAMPLE_DATA(sdata),
    .ANALOG_CFG(cfg), .CONV_ON(conv_on), .SAMPLE_STROBE(strobe), .HIGH_SPEED(),
    .CURRENT_SOURCE_ON(), .REF_PIN_CONNECT());
  acc_core_model core (.clk(clk), .rst_n(rst_n), .conv_on(conv_on), .sample_strobe(strobe),
    .cfg(cfg), .sample_data(sdata), .last_value(last));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (strobe) t_sb <= cyc;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask

  // poll the go bit, two cycles per read
  task automatic wait_idle();
    c = 0;
    v = 8'h40;
    while (v[6] && c < 3000) begin
      rd(CA, v);
      c += 2;
    end
    chk(c < 3000, 1'b1);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    trig[k] <= 1'b1;
    repeat (2) @(posedge clk);
    trig <= '0;
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(CA, v);
    chk(v, ACC_RST_CSR_A);
    rd(MX, v);
    chk(v, ACC_RST_IN_SEL);
    wr(8'h7D, 8'hA5);
    rd(8'h7D, v);
    chk(v, 8'h00);
    $display("regs done");
    for (int d = 0; d < 8; d++) begin
      ch = 5'($random(seed));
      f = (d < 2) ? 2 : (1 << d);
      wr(MX, {3'b010, ch});
      wr(CA, 8'hC0 | 8'(d));
      rd(CA, v);
      chk(v[6], 1'b1);
      wait_idle();
      chk(c > 12 * f - 4 && c <= 13 * f + 6, 1'b1);
      chk(v[4], 1'b1);
      chk(cfg.chan_valid, ch <= ACC_CH_GND);
      chk(last[4:0], ch);
      rd(ACC_OFS_RES_LO, lo);
      rd(ACC_OFS_RES_HI, v);
      chk({v, lo}, 16'(last));
      wr(MX, {3'b011, ch});
      rd(ACC_OFS_RES_HI, v);
      chk(v, last[9:2]);
      wr(CA, 8'h80);
      rd(CA, v);
      chk(v[4], 1'b1);
      wr(CA, 8'h90);
      rd(CA, v);
      chk(v[4], 1'b0);
    end
    $display("divider done");
    for (int r = 0; r < 4; r++) begin
      wr(MX, 8'(r << 6));
      tk(1);
      chk(cfg.ref_src, rtab[r]);
      chk(cfg.int_ref_on, r == 3);
    end
    wr(MX, 8'h03);
    wr(CA, 8'hC2);
    wr(MX, 8'hC5);
    wr(CA, 8'h02);
    tk(1);
    chk(cfg.channel, 5'h03);
    chk(cfg.ref_src, ACC_REF_PIN);
    chk(conv_on, 1'b1);
    rd(CA, v);
    chk(v[6], 1'b1);
    wait_idle();
    tk(3);
    chk(cfg.channel, 5'h05);
    chk(cfg.ref_src, ACC_REF_INTERNAL);
    chk(conv_on, 1'b0);
    $display("hold-off done");
    wr(CA, 8'hC8);
    wait_idle();
    @(posedge clk);
    glob <= 1'b1;
    tk(1);
    chk(irq, 1'b1);
    @(posedge clk);
    glob <= 1'b0;
    tk(1);
    chk(irq, 1'b0);
    @(posedge clk);
    glob <= 1'b1;
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    tk(1);
    chk(irq, 1'b0);
    rd(ACC_OFS_RES_LO, lo);
    exp_v = last;
    wr(CA, 8'hC0);
    wait_idle();
    chk(v[4], 1'b0);
    rd(ACC_OFS_RES_HI, v);
    chk({v, lo}, 16'(exp_v));
    $display("irq and lock done");
    for (int k = 1; k < ACC_TRG_NUM; k++) begin
      wr(ACC_OFS_CSR_B, 8'(k));
      wr(CA, 8'hB0);
      pulse(k % 13 + 1);
      tk(8);
      rd(CA, v);
      chk(v[6], 1'b0);
      pulse(k);
      tk(4);
      wait_idle();
      chk(v[4], 1'b1);
    end
    wr(ACC_OFS_CSR_B, 8'(ACC_TRG_FREE));
    wr(CA, 8'hF0);
    tk(40);
    wr(CA, 8'hB0);
    tk(40);
    rd(CA, v);
    chk(v[4], 1'b1);
    wr(CA, 8'h90);
    wait_idle();
    tk(40);
    rd(CA, v);
    chk(v[6], 1'b0);
    $display("auto done");
    wr(MX, {3'b010, ACC_CH_GAIN_CHANNEL_0});
    wr(CA, 8'hF0);
    wait_idle();
    tk(40);
    rd(CA, v);
    chk(v[6], 1'b0);
    wr(CA, 8'hF0);
    wait_idle();
    chk(c <= 48 && v[4], 1'b1);
    // triggered amplified samples all land on one amplifier clock phase
    wr(ACC_OFS_CSR_B, 8'h01);
    wr(CA, 8'hB0);
    for (int i = 0; i < 2; i++) begin
      tk(3 * i + 1);
      pulse(1);
      wait_idle();
      if (i == 0) t0 = t_sb;
    end
    chk((t_sb - t0) % (2 * ACC_AMP_DIV), 0);
    chk(t_sb > t0, 1'b1);
    $display("amplified done");
    give_verdict();
  end
endmodule // tb

bind acc_ctrl acc_monitor mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
  .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .CONV_ON(CONV_ON),
  .SAMPLE_STROBE(SAMPLE_STROBE), .ANALOG_CFG(ANALOG_CFG));
